//--- ee_cfg.svh
/*
 Constants of the serial EEPROM command port: opcodes, prefixes,
 sizes, reset values and timing. Assumes nothing of its users.
*/
`ifndef EE_CFG_SVH
`define EE_CFG_SVH
// ==============================================================
// Instruction coding
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define OP_PAGE 2'h3
`define OP_MISC 2'h0
`define PFX_FILL 2'h1
`define PFX_UNLOCK 2'h3
`define PFX_LOCK 2'h0
`define ADDR_ONES 6'h3f
`define ADDR_ZERO 6'h00
// ==============================================================
// Sizes and reset values
`define ADDR_W 6
`define WORD_W 16
`define WORDS 64
`define PAGE_WORDS 4
`define MEM_INIT 16'hffff
`define GPTR_INIT 6'h3f
// ==============================================================
// Timing
`define CLK_NS 5
`define PROG_TIME_NS 10000000
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_NS)
`endif

//--- ee_pkg.sv
/*
 Types and shared decode functions of the EEPROM command port.
 Assumes ee_cfg.svh is on the include path.
*/
`include "ee_cfg.svh"
package ee_pkg;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        LS_IDLE, LS_OPC, LS_ADDR, LS_DATA, LS_READ, LS_DONE
    } link_state_e;

    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`WORD_W-1:0] word_t;

    // Frame state, cleared whenever chip select is low.
    typedef struct packed {
        link_state_e st;
        logic [1:0] opc;
        addr_t addr;
        logic [4:0] cnt;
        logic [`WORD_W:0] sh;
        word_t wsr;
        logic pe;
        logic [2:0] nw;
        logic reading;
    } frame_s;

    // Mailbox handed to the system clock domain.
    typedef struct packed {
        logic tog;
        logic [1:0] op;
        logic pe;
        logic we;
        addr_t addr;
        logic [2:0] nw;
        logic [`PAGE_WORDS-1:0][`WORD_W-1:0] data;
    } mbox_s;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic tg_s1;
        logic tg_s2;
        logic tg_seen;
        logic pend;
        logic busy;
        logic [31:0] tmr;
        logic wen;
        logic unlock;
        addr_t gptr;
        logic gflag;
        logic gfrz;
        logic [`WORDS-1:0][`WORD_W-1:0] mem;
    } sys_s;

    // ==========================================================
    // Decode
    function automatic logic takes_data(input logic pe,
                                        input logic [1:0] op,
                                        input logic [1:0] pfx);
        return !pe && (op == `OP_WRITE || op == `OP_PAGE ||
                       (op == `OP_MISC && pfx == `PFX_FILL));
    endfunction

    function automatic logic is_prot(input addr_t a, input addr_t ptr,
                                     input logic flag);
        return !flag && a >= ptr;
    endfunction
endpackage

//--- eeprom_port.sv
/*
 Serial EEPROM command port: 64 words of 16 bits, framed serial
 instructions, write latch, guard pointer and self-timed programming.
 Assumes sclk, cs, din, wr_allow and guard_en come from one host that
 changes them away from rising sclk edges; sclk may stop between frames.
*/
`timescale 1ns/1ps
`include "ee_cfg.svh"
module eeprom_port #(
    parameter logic [31:0] prog_cycles = `PROG_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs,
    input wire logic din,
    input wire logic wr_allow,
    input wire logic guard_en,
    output logic dout,
    output logic dout_oe,
    output logic prog_busy
);
    // ==========================================================
    // Link and system domain state
    // The frame logic is cleared asynchronously by a low cs, since
    // sclk may stand still between frames and could not clear it.
    ee_pkg::frame_s fq;
    ee_pkg::frame_s fd;
    ee_pkg::mbox_s mq;
    ee_pkg::mbox_s md;
    ee_pkg::sys_s sq;
    ee_pkg::sys_s sd;
    logic frame_clr;
    logic [`ADDR_W-1:0] a_in;
    ee_pkg::word_t w_in;

    assign frame_clr = rst | ~cs;
    assign a_in = {fq.addr[`ADDR_W-2:0], din};
    assign w_in = {fq.wsr[`WORD_W-2:0], din};

    // ==========================================================
    // Link domain next state
    always_comb begin
        fd = fq;
        md = mq;
        unique case (fq.st)
            ee_pkg::LS_IDLE: begin
                if (din) begin
                    fd.st = ee_pkg::LS_OPC;
                    fd.cnt = 5'h00;
                end
            end
            ee_pkg::LS_OPC: begin
                fd.opc = {fq.opc[0], din};
                fd.cnt = fq.cnt + 5'h01;
                if (fq.cnt == 5'h01) begin
                    fd.st = ee_pkg::LS_ADDR;
                    fd.cnt = 5'h00;
                end
            end
            ee_pkg::LS_ADDR: begin
                fd.addr = a_in;
                fd.cnt = fq.cnt + 5'h01;
                if (fq.cnt == 5'h05) begin
                    fd.cnt = 5'h00;
                    fd.nw = 3'h0;
                    fd.pe = guard_en;
                    md.op = fq.opc;
                    md.pe = guard_en;
                    md.we = wr_allow;
                    md.addr = a_in;
                    md.nw = 3'h0;
                    if (ee_pkg::takes_data(guard_en, fq.opc,
                                           a_in[5:4])) begin
                        fd.st = ee_pkg::LS_DATA;
                    end else begin
                        md.tog = ~mq.tog;
                        fd.st = ee_pkg::LS_DONE;
                        if (fq.opc == `OP_READ) begin
                            fd.st = ee_pkg::LS_READ;
                            fd.reading = 1'b1;
                            if (guard_en) begin
                                fd.sh = {1'b0, sq.gptr, sq.gflag,
                                         9'h000};
                            end else begin
                                fd.sh = {1'b0, sq.mem[a_in]};
                            end
                        end
                    end
                end
            end
            ee_pkg::LS_DATA: begin
                fd.wsr = w_in;
                fd.cnt = fq.cnt + 5'h01;
                if (fq.cnt == 5'h0f) begin
                    fd.cnt = 5'h00;
                    fd.nw = fq.nw + 3'h1;
                    md.data[fq.nw[1:0]] = w_in;
                    md.nw = fq.nw + 3'h1;
                    md.tog = ~mq.tog;
                    if (fq.opc != `OP_PAGE || fq.nw == 3'h3) begin
                        fd.st = ee_pkg::LS_DONE;
                    end
                end
            end
            ee_pkg::LS_READ: begin
                fd.cnt = fq.cnt + 5'h01;
                fd.sh = {fq.sh[`WORD_W-1:0], 1'b0};
                if (fq.cnt == 5'h10 && !fq.pe) begin
                    fd.addr = fq.addr + 6'h01;
                    fd.sh = {sq.mem[fq.addr + 6'h01], 1'b0};
                    fd.cnt = 5'h01;
                end
            end
            ee_pkg::LS_DONE: begin
                fd.st = ee_pkg::LS_DONE;
            end
        endcase
    end

    always_ff @(posedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            fq <= '0;
        end else begin
            fq <= fd;
        end
    end

    // The mailbox survives the end of the frame so that the system
    // side can still act on it after cs has fallen.
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            mq <= '0;
        end else begin
            mq <= md;
        end
    end

    // ==========================================================
    // System domain next state
    always_comb begin
        logic ok;
        logic cs_fall;
        logic [`ADDR_W-1:0] wa;
        ok = 1'b1;
        cs_fall = 1'b0;
        wa = '0;
        sd = sq;
        sd.cs_s1 = cs;
        sd.cs_s2 = sq.cs_s1;
        sd.cs_s3 = sq.cs_s2;
        sd.tg_s1 = mq.tog;
        sd.tg_s2 = sq.tg_s1;
        cs_fall = sq.cs_s3 & ~sq.cs_s2;
        if (sq.busy) begin
            sd.tmr = sq.tmr + 32'h1;
            if (sq.tmr == prog_cycles - 32'h1) begin
                sd.busy = 1'b0;
            end
        end
        if (sq.tg_s2 != sq.tg_seen) begin
            sd.tg_seen = sq.tg_s2;
            sd.unlock = 1'b0;
            if (ee_pkg::takes_data(mq.pe, mq.op, mq.addr[5:4])) begin
                sd.pend = 1'b1;
            end else if (!mq.pe && mq.op == `OP_MISC && mq.we) begin
                if (mq.addr[5:4] == `PFX_UNLOCK) begin
                    sd.wen = 1'b1;
                end else if (mq.addr[5:4] == `PFX_LOCK) begin
                    sd.wen = 1'b0;
                end
            end else if (mq.pe && mq.we && sq.wen) begin
                if (mq.op == `OP_MISC &&
                    mq.addr[5:4] == `PFX_UNLOCK) begin
                    sd.unlock = 1'b1;
                end else if (sq.unlock && !sq.gfrz) begin
                    if (mq.op == `OP_WRITE) begin
                        sd.gptr = mq.addr;
                        sd.gflag = 1'b0;
                    end else if (mq.op == `OP_PAGE &&
                                 mq.addr == `ADDR_ONES) begin
                        sd.gptr = `ADDR_ONES;
                        sd.gflag = 1'b1;
                    end else if (mq.op == `OP_MISC &&
                                 mq.addr == `ADDR_ZERO) begin
                        sd.gfrz = 1'b1;
                    end
                end
            end
        end
        // Programming is refused while a cycle runs, since the array
        // is still being written.
        if (cs_fall && sq.pend) begin
            sd.pend = 1'b0;
            if (mq.we && sq.wen && !sq.busy) begin
                if (mq.op == `OP_WRITE) begin
                    if (!ee_pkg::is_prot(mq.addr, sq.gptr,
                                         sq.gflag)) begin
                        sd.mem[mq.addr] = mq.data[0];
                        sd.busy = 1'b1;
                    end
                end else if (mq.op == `OP_PAGE) begin
                    for (int i = 0; i < `PAGE_WORDS; i++) begin
                        wa = {mq.addr[5:2], mq.addr[1:0] + 2'(i)};
                        if (i < int'(mq.nw) &&
                            ee_pkg::is_prot(wa, sq.gptr, sq.gflag)) begin
                            ok = 1'b0;
                        end
                    end
                    if (ok) begin
                        for (int i = 0; i < `PAGE_WORDS; i++) begin
                            wa = {mq.addr[5:2], mq.addr[1:0] + 2'(i)};
                            if (i < int'(mq.nw)) begin
                                sd.mem[wa] = mq.data[i];
                            end
                        end
                        sd.busy = 1'b1;
                    end
                end else if (sq.gflag) begin
                    for (int i = 0; i < `WORDS; i++) begin
                        sd.mem[i] = mq.data[0];
                    end
                    sd.busy = 1'b1;
                end
                sd.tmr = 32'h0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sq <= '0;
            sq.gptr <= `GPTR_INIT;
            sq.gflag <= 1'b1;
            sq.wen <= 1'b0;
            for (int i = 0; i < `WORDS; i++) begin
                sq.mem[i] <= `MEM_INIT;
            end
        end else begin
            sq <= sd;
        end
    end

    // ==========================================================
    // Outputs
    // Outside a read the pin reports programming status, which the
    // system clock keeps current even while sclk stands still.
    assign dout = fq.reading ? fq.sh[`WORD_W] : ~sq.busy;
    assign dout_oe = sq.cs_s2;
    assign prog_busy = sq.busy;
endmodule

//--- eeprom_port_asserts.sv
/*
 Checker of the EEPROM command port, bound to the port module.
 Assumes one host on the link and the design's prog_cycles value.
*/
`timescale 1ns/1ps
module eeprom_port_chk #(
    parameter logic [31:0] prog_cycles = 32'h32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs,
    input wire logic din,
    input wire logic wr_allow,
    input wire logic guard_en,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic prog_busy
);
    // ==========================================================
    // Helper state
    typedef struct packed {
        logic sq;
        logic inf;
        logic [7:0] low;
        logic [31:0] bc;
    } mon_s;
    mon_s m_q;
    mon_s m_d;
    // Once sclk has risen in a frame, dout may carry link data, so the
    // busy and ready checks only look at frames not yet clocked.
    always_comb begin
        m_d.sq = sclk;
        m_d.inf = cs && (m_q.inf || (sclk && !m_q.sq));
        m_d.low = cs ? 8'h00 : m_q.low + {7'h0, m_q.low != 8'hff};
        m_d.bc = prog_busy ? m_q.bc + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            m_q <= '0;
        end else begin
            m_q <= m_d;
        end
    end
    // ==========================================================
    // Properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_oe_rise: assert property ($rose(cs) |-> ##[1:3] dout_oe)
        else $error("dout_oe did not follow cs high");
    a_oe_fall: assert property ($fell(cs) |-> ##[1:3] !dout_oe)
        else $error("dout_oe did not follow cs low");
    a_prog_start: assert property ($rose(prog_busy) |->
        !cs && m_q.low inside {[8'h02:8'h08]})
        else $error("programming started without a cs fall");
    a_prog_length: assert property ($fell(prog_busy) |->
        m_q.bc inside {[prog_cycles - 32'h1:prog_cycles + 32'h1]})
        else $error("programming length wrong");
    a_prog_bound: assert property (prog_busy |-> m_q.bc <= prog_cycles)
        else $error("programming too long");
    a_busy_dout: assert property (
        (cs && !m_q.inf && prog_busy) [*4] |-> !dout)
        else $error("dout not busy while programming");
    a_ready_dout: assert property (
        (cs && !m_q.inf && !prog_busy) [*4] |-> dout)
        else $error("dout not ready while idle");
    a_dout_edge: assert property (
        cs && m_q.inf && $changed(dout) |-> sclk)
        else $error("dout changed away from a rising sclk");
    a_reset_idle: assert property ($fell(rst) |-> !prog_busy)
        else $error("programming active after reset");
    c_prog: cover property ($fell(prog_busy));
    c_read: cover property (m_q.inf && $fell(dout));
    c_ready: cover property (cs && $rose(dout));
endmodule
bind eeprom_port eeprom_port_chk #(.prog_cycles(prog_cycles)) chk_i (
    .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs(cs), .din(din),
    .wr_allow(wr_allow), .guard_en(guard_en), .dout(dout),
    .dout_oe(dout_oe), .prog_busy(prog_busy));

//--- ee_host.sv
/*
 Host model: serial bus master on the link of the command port.
 Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module ee_host (
    output logic sclk,
    output logic cs,
    output logic din,
    output logic wr_allow,
    output logic guard_en,
    input wire logic dout
);
    // ==========================================================
    // Link driving
    initial begin
        sclk = 1'b0;
        cs = 1'b0;
        din = 1'b0;
        wr_allow = 1'b0;
        guard_en = 1'b0;
    end
    task automatic set_cs(input logic v);
        cs = v;
    endtask
    // Bit k of a frame is tx[n-1-k]; rx gathers dout just before each
    // rising edge. The odd lead-in keeps sclk off the system clock phase.
    // The 80 ns bit period is far below the one microsecond floor that a
    // real host keeps; the port has no minimum, and it keeps runs short.
    task automatic xfer(input int n, input logic [79:0] tx,
                        input logic we, input logic ge,
                        output logic [79:0] rx);
        rx = '0;
        #300.7;
        wr_allow = we;
        guard_en = ge;
        cs = 1'b1;
        #60;
        for (int k = 0; k < n; k++) begin
            din = tx[n - 1 - k];
            #39 rx = {rx[78:0], dout};
            sclk = 1'b1;
            #40 sclk = 1'b0;
            #1;
        end
        cs = 1'b0;
        din = ~din;
        guard_en = 1'b0;
    endtask
endmodule

//--- tb.sv
/*
 Testbench of the EEPROM command port: frames sent through the host
 model, busy and ready polling, guard pointer handling.
 Assumes the design files and ee_host.sv are compiled before it.
*/
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] PC = 32'hc8;
    logic clk_sys;
    logic rst;
    wire logic sclk, cs, din, wr_allow, guard_en;
    wire logic dout, dout_oe, prog_busy;
    int errors;
    int checks_done;
    logic [79:0] rx;
    eeprom_port #(.prog_cycles(PC)) dut (.clk_sys(clk_sys), .rst(rst),
        .sclk(sclk), .cs(cs), .din(din), .wr_allow(wr_allow),
        .guard_en(guard_en), .dout(dout), .dout_oe(dout_oe),
        .prog_busy(prog_busy));
    ee_host host (.sclk(sclk), .cs(cs), .din(din), .wr_allow(wr_allow),
        .guard_en(guard_en), .dout(dout));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ==========================================================
    // Checking and frames
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // f is {wr_allow, guard_en, programming expected}.
    task automatic prog(input int n, input logic [79:0] tx,
                        input logic [2:0] f);
        host.xfer(n, tx, f[2], f[1], rx);
        repeat (8) @(posedge clk_sys);
        #1;
        chk("prog_busy", 16'(prog_busy), 16'(f[0]));
        if (f[0]) begin
            repeat (52) @(posedge clk_sys);
            #1;
            host.set_cs(1'b1);
            repeat (4) @(posedge clk_sys);
            #1;
            chk("busy dout", 16'(dout), 16'h0000);
            chk("dout_oe high", 16'(dout_oe), 16'h0001);
            for (int i = 0; i < 400 && prog_busy !== 1'b0; i++) begin
                @(posedge clk_sys);
            end
            repeat (4) @(posedge clk_sys);
            #1;
            chk("ready dout", 16'(dout), 16'h0001);
            host.set_cs(1'b0);
            repeat (4) @(posedge clk_sys);
            #1;
            chk("dout_oe low", 16'(dout_oe), 16'h0000);
        end
    endtask
    task automatic rdchk(input logic [5:0] a, input int nw,
                         input logic [63:0] exp);
        host.xfer(10 + 16 * nw, 80'({3'b110, a}) << (1 + 16 * nw),
                  1'b0, 1'b0, rx);
        chk("dummy", 16'(rx[16 * nw]), 16'h0000);
        for (int i = 0; i < nw; i++) begin
            chk("word", rx[16 * (nw - 1 - i) +: 16],
                exp[63 - 16 * i -: 16]);
        end
    endtask
    task automatic gfetch(input logic [5:0] p, input logic f);
        host.xfer(17, 80'({3'b110, 6'h00}) << 8, 1'b0, 1'b1, rx);
        chk("guard dummy", 16'(rx[7]), 16'h0000);
        chk("guard ptr", 16'(rx[6:1]), 16'(p));
        chk("guard flag", 16'(rx[0]), 16'(f));
    endtask
    // ==========================================================
    // Sequence
    initial begin
        rst = 1'b1;
        errors = 0;
        checks_done = 0;
        repeat (8) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk_sys);
        gfetch(6'h3f, 1'b1);
        prog(25, 80'({3'b101, 6'h05, 16'h1234}), 3'b100);
        prog(9, 80'({3'b100, 6'h30}), 3'b100);
        prog(25, 80'({3'b101, 6'h06, 16'h5678}), 3'b000);
        prog(25, 80'({3'b101, 6'h05, 16'h1234}), 3'b101);
        rdchk(6'h05, 2, 64'h1234_ffff_0000_0000);
        prog(57, 80'({3'b111, 6'h0a, 48'h111122223333}),
             3'b101);
        rdchk(6'h08, 4, 64'h3333_ffff_1111_2222);
        prog(9, 80'({3'b101, 6'h21}), 3'b110);
        gfetch(6'h3f, 1'b1);
        prog(9, 80'({3'b100, 6'h30}), 3'b110);
        prog(9, 80'({3'b101, 6'h21}), 3'b110);
        gfetch(6'h21, 1'b0);
        prog(25, 80'({3'b101, 6'h21, 16'h0000}), 3'b100);
        prog(41, 80'({3'b111, 6'h20, 32'h0001_0002}), 3'b100);
        rdchk(6'h20, 2, 64'hffff_ffff_0000_0000);
        prog(25, 80'({3'b100, 6'h10, 16'ha5a5}), 3'b100);
        prog(9, 80'({3'b100, 6'h30}), 3'b110);
        prog(9, 80'({3'b111, 6'h3f}), 3'b110);
        gfetch(6'h3f, 1'b1);
        prog(25, 80'({3'b100, 6'h10, 16'ha5a5}), 3'b101);
        rdchk(6'h3f, 2, 64'ha5a5_a5a5_0000_0000);
        prog(9, 80'({3'b100, 6'h30}), 3'b110);
        prog(9, 80'({3'b100, 6'h00}), 3'b110);
        prog(9, 80'({3'b100, 6'h30}), 3'b110);
        prog(9, 80'({3'b101, 6'h10}), 3'b110);
        gfetch(6'h3f, 1'b1);
        prog(9, 80'({3'b100, 6'h00}), 3'b100);
        prog(25, 80'({3'b101, 6'h05, 16'h0000}), 3'b100);
        print_verdict();
    end
    initial begin
        #400000;
        errors++;
        print_verdict();
    end
endmodule
